// >>> tb/sram_jtag_test_access_port_test.sv
// Self-checking bench for the test access port and its instruction stream
`timescale 1ns/1ns
`default_nettype none
module sram_jtag_test_access_port_test;
    logic                        sys_clk;
    logic                        arst_n;
    logic                        tck;
    logic                        tms;
    logic                        tdi;
    logic                        tdo;
    logic                        tdo_oe;
    logic [tap_pkg::BSR_LEN-1:0] ring_in;
    logic                        highz_out;
    logic                        instr_valid;
    logic                        instr_ready;
    logic [tap_pkg::IR_LEN-1:0]  instr_data;
    logic                        absent_oe;
    logic                        absent_valid;
    int                          n_errors;
    int                          cmp_count;

    sram_tap i_dut (
        .SYS_CLK     (sys_clk),
        .ARST_N      (arst_n),
        .TCK         (tck),
        .TMS         (tms),
        .TDI         (tdi),
        .TDO         (tdo),
        .TDO_OE      (tdo_oe),
        .RING_IN     (ring_in),
        .HIGHZ_OUT   (highz_out),
        .INSTR_VALID (instr_valid),
        .INSTR_READY (instr_ready),
        .INSTR_DATA  (instr_data)
    );

    // Variant without a port shares the link and must stay silent
    sram_tap #(
        .BGA_VARIANT (1'b0)
    ) i_dut_absent (
        .SYS_CLK     (sys_clk),
        .ARST_N      (arst_n),
        .TCK         (tck),
        .TMS         (tms),
        .TDI         (tdi),
        .TDO         (),
        .TDO_OE      (absent_oe),
        .RING_IN     (ring_in),
        .HIGHZ_OUT   (),
        .INSTR_VALID (absent_valid),
        .INSTR_READY (instr_ready),
        .INSTR_DATA  ()
    );

    tap_ctrl_model i_ctrl (
        .TCK    (tck),
        .TMS    (tms),
        .TDI    (tdi),
        .TDO    (tdo),
        .TDO_OE (tdo_oe)
    );

    initial sys_clk = 1'h0;
    always #2 sys_clk = ~sys_clk;

    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // From idle: capture, shift len+8 bits, update, back to idle
    task automatic shift_dr(
        input  int           len,
        input  logic [63:0]  cap,
        input  logic [7:0]   din
    );
        logic        so;
        logic        oe;
        logic [63:0] got;
        logic [63:0] mask;
        int          n;
        n    = len + 8;
        got  = 64'h0000_0000_0000_0000;
        mask = (64'h0000_0000_0000_0001 << n) - 64'h0000_0000_0000_0001;
        i_ctrl.drive_bit(1'h1, 1'h1, so, oe);
        i_ctrl.drive_bit(1'h0, 1'h1, so, oe);
        check(64'(oe), 64'h0000_0000_0000_0000);
        i_ctrl.drive_bit(1'h0, 1'h1, so, oe);
        got[0] = so;
        check(64'(oe), 64'h0000_0000_0000_0001);
        check(64'(absent_oe), 64'h0000_0000_0000_0000);
        for (int i = 0; i < n; i++) begin
            i_ctrl.drive_bit(1'(i == n - 1), (i < 8) ? din[i] : 1'h0, so, oe);
            got[i+1] = so;
        end
        check(64'(oe), 64'h0000_0000_0000_0000);
        check(got & mask, cap | (64'(din) << len));
        i_ctrl.drive_bit(1'h1, 1'h1, so, oe);
        i_ctrl.drive_bit(1'h0, 1'h1, so, oe);
    endtask : shift_dr

    // From idle: load an instruction, check the captured low bits
    task automatic load_ir(input logic [2:0] code);
        logic       so;
        logic       oe;
        logic [2:0] cap;
        i_ctrl.drive_bit(1'h1, 1'h1, so, oe);
        i_ctrl.drive_bit(1'h1, 1'h1, so, oe);
        i_ctrl.drive_bit(1'h0, 1'h1, so, oe);
        i_ctrl.drive_bit(1'h0, 1'h1, so, oe);
        cap[0] = so;
        for (int i = 0; i < 3; i++) begin
            i_ctrl.drive_bit(1'(i == 2), code[i], so, oe);
            if (i < 2) begin
                cap[i+1] = so;
            end
        end
        check(64'(cap[1:0]), 64'h0000_0000_0000_0001);
        i_ctrl.drive_bit(1'h1, 1'h1, so, oe);
        i_ctrl.drive_bit(1'h0, 1'h1, so, oe);
    endtask : load_ir

    // Take one instruction word from the stream, bounded wait
    task automatic pop(input logic [2:0] exp);
        for (int k = 0; k < 200 && instr_valid !== 1'h1; k++) begin
            @(negedge sys_clk);
        end
        if (instr_valid !== 1'h1) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time,
                     instr_valid, 1'h1);
            summarize();
        end
        check(64'(instr_data), 64'(exp));
        @(posedge sys_clk);
        instr_ready <= 1'h1;
        @(posedge sys_clk);
        instr_ready <= 1'h0;
        @(negedge sys_clk);
    endtask : pop

    task automatic t_power_up;
        logic so;
        logic oe;
        check(64'(tdo_oe), 64'h0000_0000_0000_0000);
        check(64'(instr_valid), 64'h0000_0000_0000_0000);
        check(64'(highz_out), 64'h0000_0000_0000_0000);
        i_ctrl.drive_bit(1'h0, 1'h1, so, oe);
        shift_dr(32, 64'(tap_pkg::ID_VALUE), 8'hA5);
        $display("Test power_up done");
    endtask : t_power_up

    // Every code: stream word, output float flag, selected register
    task automatic t_codes;
        logic [2:0] c;
        logic [7:0] ring_v;
        logic       so;
        logic       oe;
        for (int i = 0; i < 8; i++) begin
            c      = 3'(i);
            ring_v = 8'h5A ^ {5'h00, c};
            @(posedge sys_clk);
            ring_in <= ring_v;
            load_ir(c);
            pop(c);
            // Float flag follows the instruction one test clock rise later
            i_ctrl.drive_bit(1'h0, 1'h1, so, oe);
            check(64'(highz_out), 64'(c == 3'h0 || c == 3'h2));
            if (c == 3'h1) begin
                shift_dr(32, 64'(tap_pkg::ID_VALUE), 8'h3C);
            end else if (c == 3'h0 || c == 3'h2 || c == 3'h4) begin
                shift_dr(8, 64'(ring_v), 8'hC6);
            end else begin
                shift_dr(1, 64'h0000_0000_0000_0000, 8'h96);
            end
        end
        $display("Test codes done");
    endtask : t_codes

    // Stream stalled: two buffered, one waiting, fourth dropped
    task automatic t_stall;
        load_ir(3'h3);
        load_ir(3'h5);
        load_ir(3'h6);
        load_ir(3'h4);
        repeat (20) @(negedge sys_clk);
        check(64'(instr_valid), 64'h0000_0000_0000_0001);
        check(64'(instr_data), 64'h0000_0000_0000_0003);
        pop(3'h3);
        pop(3'h5);
        pop(3'h6);
        repeat (20) @(negedge sys_clk);
        check(64'(instr_valid), 64'h0000_0000_0000_0000);
        shift_dr(8, 64'(ring_in), 8'h81);
        $display("Test stall done");
    endtask : t_stall

    task automatic t_mode_reset;
        logic so;
        logic oe;
        load_ir(3'h7);
        pop(3'h7);
        for (int i = 0; i < 5; i++) begin
            i_ctrl.drive_bit(1'h1, 1'h1, so, oe);
        end
        i_ctrl.drive_bit(1'h0, 1'h1, so, oe);
        check(64'(oe), 64'h0000_0000_0000_0000);
        shift_dr(32, 64'(tap_pkg::ID_VALUE), 8'h5F);
        check(64'(absent_valid), 64'h0000_0000_0000_0000);
        $display("Test mode_reset done");
    endtask : t_mode_reset

    initial begin
        n_errors    = 0;
        cmp_count   = 0;
        arst_n      = 1'h0;
        ring_in     = 8'h00;
        instr_ready = 1'h0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'h1;
        repeat (4) @(negedge sys_clk);
        t_power_up();
        t_codes();
        t_stall();
        t_mode_reset();
        summarize();
    end
endmodule : sram_jtag_test_access_port_test
`default_nettype wire

// >>> tb/tap_ctrl_model.sv
// Board-level scan controller model driving the test link
`timescale 1ns/1ns
`default_nettype none
module tap_ctrl_model (
    output logic      TCK,
    output logic      TMS,
    output logic      TDI,
    input  wire logic TDO,
    input  wire logic TDO_OE
);
    // Idle: clock parked low, data lines at their pulled-up level
    initial begin
        TCK = 1'h0;
        TMS = 1'h1;
        TDI = 1'h1;
    end

    // One link bit; mode and data settle a quarter period before the rise
    task automatic drive_bit(
        input  logic ms,
        input  logic di,
        output logic so,
        output logic oe
    );
        TMS = ms;
        TDI = di;
        #20;
        TCK = 1'h1;
        #40;
        TCK = 1'h0;
        #20;
        // Sampled midway through the low phase, after the falling-edge launch
        so  = TDO;
        oe  = TDO_OE;
        TMS = 1'h1;
        TDI = 1'h1;
    endtask : drive_bit
endmodule : tap_ctrl_model
`default_nettype wire

// >>> verilog/sram_tap.sv
// Boundary-scan test access port with system-side instruction stream
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Port exists only on the grid array variant; otherwise held in reset.
// - Partial function set, never disturbs other compliant ports in chain.
// - Holds state machine, instruction, boundary, bypass and ID registers.
// - Mode select and data input read high when left unconnected.
// - Power-up lands in reset state without disturbing the memory.
// - Test clock drives only port logic; inputs captured on rising edge.
// - Serial output and its enable change on falling edge; HIGHZ_OUT, INSTR_VALID and INSTR_DATA change on the system clock rising edge instead.
// - Mode select sampled each rising edge to steer the state machine.
// - Exactly one register, chosen by instruction, sits between pins.
// - Serial input enters the selected register's top bit.
// - Serial output shows the selected register's bottom bit.
// - Serial output driver enabled or floated by controller state.
// - Five rising edges with mode select high reset the controller.
// - Three-bit instruction register loads ID instruction on reset.
// - Instruction capture loads low bits with pattern one then zero.
// - Bypass register is one bit, one stage of delay.
module sram_tap #(
    parameter bit BGA_VARIANT = 1'b1
) (
    input  wire logic                        SYS_CLK,
    input  wire logic                        ARST_N,
    input  wire logic                        TCK,
    input  wire logic                        TMS,
    input  wire logic                        TDI,
    output logic                             TDO,
    output logic                             TDO_OE,
    input  wire logic [tap_pkg::BSR_LEN-1:0] RING_IN,
    output logic                             HIGHZ_OUT,
    output logic                             INSTR_VALID,
    input  wire logic                        INSTR_READY,
    output logic [tap_pkg::IR_LEN-1:0]       INSTR_DATA
);

    // Test clock domain
    tap_pkg::tap_state_t               state_r;
    tap_pkg::tap_state_t               state_nxt;
    logic [tap_pkg::IR_LEN-1:0]        ir_r;
    logic [tap_pkg::IR_LEN-1:0]        ir_sh_r;
    logic [tap_pkg::ID_LEN-1:0]        id_sh_r;
    logic [tap_pkg::BSR_LEN-1:0]       bsr_sh_r;
    logic                              byp_r;
    logic [tap_pkg::BSR_LEN-1:0]       ring_s1_r;
    logic [tap_pkg::BSR_LEN-1:0]       ring_s2_r;
    logic                              highz_tck_r;
    logic                              sel_id;
    logic                              sel_bsr;
    logic                              sel_byp;
    logic                              dr_lsb;
    logic                              tdo_nxt;
    logic                              shifting;
    logic                              tms_eff;

    // Crossing to system domain
    logic [tap_pkg::IR_LEN-1:0]        xfer_data_r;
    logic                              req_tgl_r;
    logic                              ack_s1_r;
    logic                              ack_s2_r;
    logic                              pending;

    // System clock domain
    logic                              req_s1_r;
    logic                              req_s2_r;
    logic                              ack_tgl_r;
    logic                              hz_s1_r;
    logic                              req_seen;
    logic                              buf_ready;
    logic                              push;

    // Smaller variant has no port: controller pinned in reset
    assign tms_eff = BGA_VARIANT ? TMS : 1'b1;

    // Next-state function
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            tap_pkg::TLR:
                state_nxt = tms_eff ? tap_pkg::TLR : tap_pkg::RTI;
            tap_pkg::RTI:
                state_nxt = tms_eff ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_DR:
                state_nxt = tms_eff ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR:
                state_nxt = tms_eff ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::SH_DR:
                state_nxt = tms_eff ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::EX1_DR:
                state_nxt = tms_eff ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
            tap_pkg::PAU_DR:
                state_nxt = tms_eff ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
            tap_pkg::EX2_DR:
                state_nxt = tms_eff ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
            tap_pkg::UPD_DR:
                state_nxt = tms_eff ? tap_pkg::SEL_DR : tap_pkg::RTI;
            // Any path with mode select high reaches reset in five edges
            tap_pkg::SEL_IR:
                state_nxt = tms_eff ? tap_pkg::TLR : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR:
                state_nxt = tms_eff ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::SH_IR:
                state_nxt = tms_eff ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::EX1_IR:
                state_nxt = tms_eff ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
            tap_pkg::PAU_IR:
                state_nxt = tms_eff ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
            tap_pkg::EX2_IR:
                state_nxt = tms_eff ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
            tap_pkg::UPD_IR:
                state_nxt = tms_eff ? tap_pkg::SEL_DR : tap_pkg::RTI;
        endcase
    end

    // Power-up lands in reset; pad pull-ups keep open inputs high
    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_r <= tap_pkg::TLR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Instruction shift path
    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ir_sh_r <= tap_pkg::IR_RESET_VAL;
        end else if (state_r == tap_pkg::CAP_IR) begin
            ir_sh_r <= tap_pkg::IR_CAPTURE;
        end else if (state_r == tap_pkg::SH_IR) begin
            ir_sh_r <= {TDI, ir_sh_r[tap_pkg::IR_LEN-1:1]};
        end
    end

    // Current instruction
    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ir_r <= tap_pkg::IR_RESET_VAL;
        end else if (state_r == tap_pkg::TLR) begin
            ir_r <= tap_pkg::IR_RESET_VAL;
        end else if (state_r == tap_pkg::UPD_IR) begin
            ir_r <= ir_sh_r;
        end
    end

    // Register select; unknown codes fall back to bypass, chain-safe
    always_comb begin
        sel_id  = 1'b0;
        sel_bsr = 1'b0;
        sel_byp = 1'b0;
        unique case (ir_r)
            tap_pkg::OP_IDCODE: sel_id  = 1'b1;
            tap_pkg::OP_EXTEST,
            tap_pkg::OP_SAMPLEZ,
            tap_pkg::OP_SAMPLE: sel_bsr = 1'b1;
            default:            sel_byp = 1'b1;
        endcase
    end

    // Identification register
    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            id_sh_r <= tap_pkg::ID_VALUE;
        end else if (sel_id && state_r == tap_pkg::CAP_DR) begin
            id_sh_r <= tap_pkg::ID_VALUE;
        end else if (sel_id && state_r == tap_pkg::SH_DR) begin
            id_sh_r <= {TDI, id_sh_r[tap_pkg::ID_LEN-1:1]};
        end
    end

    // Ring pins come from the memory's domain
    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ring_s1_r <= tap_pkg::BSR_RESET;
            ring_s2_r <= tap_pkg::BSR_RESET;
        end else begin
            ring_s1_r <= RING_IN;
            ring_s2_r <= ring_s1_r;
        end
    end

    // Boundary register: capture only, no preload stage
    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            bsr_sh_r <= tap_pkg::BSR_RESET;
        end else if (sel_bsr && state_r == tap_pkg::CAP_DR) begin
            bsr_sh_r <= ring_s2_r;
        end else if (sel_bsr && state_r == tap_pkg::SH_DR) begin
            bsr_sh_r <= {TDI, bsr_sh_r[tap_pkg::BSR_LEN-1:1]};
        end
    end

    // Single-stage bypass
    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            byp_r <= tap_pkg::BYP_CAPTURE;
        end else if (sel_byp && state_r == tap_pkg::CAP_DR) begin
            byp_r <= tap_pkg::BYP_CAPTURE;
        end else if (sel_byp && state_r == tap_pkg::SH_DR) begin
            byp_r <= TDI;
        end
    end

    // Output select
    always_comb begin
        dr_lsb   = sel_id  ? id_sh_r[0]  :
                   sel_bsr ? bsr_sh_r[0] : byp_r;
        shifting = (state_r == tap_pkg::SH_DR) ||
                   (state_r == tap_pkg::SH_IR);
        tdo_nxt  = (state_r == tap_pkg::SH_IR) ? ir_sh_r[0] : dr_lsb;
    end

    // Half-cycle launch gives the next device full hold margin
    always_ff @(negedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            TDO    <= 1'b0;
            TDO_OE <= 1'b0;
        end else begin
            TDO    <= tdo_nxt;
            TDO_OE <= shifting && BGA_VARIANT;
        end
    end

    // Outputs floated by extest and sample-z
    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            highz_tck_r <= 1'b0;
        end else begin
            highz_tck_r <= (ir_r == tap_pkg::OP_EXTEST) ||
                           (ir_r == tap_pkg::OP_SAMPLEZ);
        end
    end

    // Instruction word handed over by toggle handshake
    assign pending = req_tgl_r ^ ack_s2_r;

    // A second update before the ack arrives is not forwarded
    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            xfer_data_r <= tap_pkg::IR_RESET_VAL;
            req_tgl_r   <= 1'b0;
        end else if (state_r == tap_pkg::UPD_IR && !pending) begin
            xfer_data_r <= ir_sh_r;
            req_tgl_r   <= !req_tgl_r;
        end
    end

    always_ff @(posedge TCK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    // System side
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            req_s1_r  <= 1'b0;
            req_s2_r  <= 1'b0;
            hz_s1_r   <= 1'b0;
            HIGHZ_OUT <= 1'b0;
        end else begin
            req_s1_r  <= req_tgl_r;
            req_s2_r  <= req_s1_r;
            hz_s1_r   <= highz_tck_r;
            HIGHZ_OUT <= hz_s1_r;
        end
    end

    // Ack withheld while the buffer is full: back-pressure to source
    assign req_seen = req_s2_r ^ ack_tgl_r;
    assign push     = req_seen && buf_ready;

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_tgl_r <= 1'b0;
        end else if (push) begin
            ack_tgl_r <= !ack_tgl_r;
        end
    end

    word_buf2 #(
        .W (tap_pkg::IR_LEN)
    ) u_instr_buf (
        .clk       (SYS_CLK),
        .arst_n    (ARST_N),
        .in_valid  (req_seen),
        .in_ready  (buf_ready),
        .in_data   (xfer_data_r),
        .out_valid (INSTR_VALID),
        .out_ready (INSTR_READY),
        .out_data  (INSTR_DATA)
    );

    // Checks
    sequence s_tms_high5;
        tms_eff [*5];
    endsequence

    a_tms_reset_five: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        s_tms_high5 |=> state_r == tap_pkg::TLR)
        else $error("five high mode selects did not reset");

    a_reset_loads_id: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        state_r == tap_pkg::TLR |=> ir_r == tap_pkg::OP_IDCODE)
        else $error("reset did not load id instruction");

    a_ir_capture_bits: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        state_r == tap_pkg::CAP_IR |=> ir_sh_r[1:0] == 2'b01)
        else $error("instruction capture pattern wrong");

    a_ir_update_takes: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        state_r == tap_pkg::UPD_IR |=> ir_r == $past(ir_sh_r))
        else $error("update did not load shifted instruction");

    sequence s_bypass_shift;
        (state_r == tap_pkg::SH_DR && sel_byp) [*2];
    endsequence

    a_bypass_one_stage: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        s_bypass_shift |-> TDO == $past(TDI))
        else $error("bypass delay is not one stage");

    a_tdo_drive_state: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        TDO_OE == (shifting && BGA_VARIANT))
        else $error("serial output enable disagrees with state");

    a_tdo_id_lsb: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        state_r == tap_pkg::SH_DR && sel_id |-> TDO == id_sh_r[0])
        else $error("serial output not id register lsb");

    a_id_capture_val: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        state_r == tap_pkg::CAP_DR && sel_id
        |=> id_sh_r == tap_pkg::ID_VALUE)
        else $error("id register capture wrong");

    a_id_shift_msb: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        state_r == tap_pkg::SH_DR && sel_id
        |=> id_sh_r[tap_pkg::ID_LEN-1] == $past(TDI))
        else $error("serial input not entering msb");

    a_variant_silent: assert property (
        @(posedge TCK) disable iff (!ARST_N)
        !BGA_VARIANT |-> !TDO_OE && state_r == tap_pkg::TLR)
        else $error("port active on variant without it");

endmodule : sram_tap
`default_nettype wire

// >>> verilog/tap_pkg.sv
// Constants, encodings and state type of the SRAM test access port
package tap_pkg;

    // Instruction register
    localparam int          IR_LEN       = 3;
    localparam logic [2:0]  IR_CAPTURE   = 3'h1;
    localparam logic [2:0]  IR_RESET_VAL = 3'h1;

    // Instruction codes
    localparam logic [2:0]  OP_EXTEST    = 3'h0;
    localparam logic [2:0]  OP_IDCODE    = 3'h1;
    localparam logic [2:0]  OP_SAMPLEZ   = 3'h2;
    localparam logic [2:0]  OP_SAMPLE    = 3'h4;
    localparam logic [2:0]  OP_BYPASS    = 3'h7;

    // Identification register, value is arbitrary
    localparam int          ID_LEN       = 32;
    localparam logic [31:0] ID_VALUE     = 32'h0000_0001;

    // Boundary scan register length and capture reset value
    localparam int          BSR_LEN      = 8;
    localparam logic [7:0]  BSR_RESET    = 8'h00;

    // Bypass register capture value
    localparam logic        BYP_CAPTURE  = 1'b0;

    // Synchroniser depth in flip-flops
    localparam int          SYNC_STAGES  = 2;

    typedef enum logic [3:0] {
        TLR, RTI,
        SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } tap_state_t;

endpackage : tap_pkg

// >>> verilog/word_buf2.sv
// Two-entry valid/ready buffer, outputs straight from flip-flops
`timescale 1ns/1ns
`default_nettype none
module word_buf2 #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic [W-1:0] tail_r;
    logic         tail_v_r;
    logic         push;
    logic         pop;

    // Full only when the second slot is taken, so ready is honest
    assign in_ready = !tail_v_r;
    assign push     = in_valid && !tail_v_r;
    assign pop      = out_valid && out_ready;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid <= 1'b0;
            out_data  <= '0;
            tail_v_r  <= 1'b0;
            tail_r    <= '0;
        end else if (!out_valid || pop) begin
            if (tail_v_r) begin
                out_valid <= 1'b1;
                out_data  <= tail_r;
                tail_v_r  <= push;
                if (push) begin
                    tail_r <= in_data;
                end
            end else begin
                out_valid <= push;
                if (push) begin
                    out_data <= in_data;
                end
            end
        end else if (push) begin
            tail_v_r <= 1'b1;
            tail_r   <= in_data;
        end
    end

    // Stalled head word neither vanishes nor changes
    a_stall_holds_word: assert property (
        @(posedge clk) disable iff (!arst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffered word lost under stall");

endmodule : word_buf2
`default_nettype wire
